//--- logic/sesl_cfg.svh
`ifndef SESL_CFG_SVH
`define SESL_CFG_SVH

// ****************************************
// Clock and timing
// ****************************************
// Core clock rate in MHz
`define SESL_CLK_MHZ 250
// Internal write cycle time in ns
`define SESL_TW_NS 5000000
// Write cycle in core cycles, rounded down
`define SESL_TW_CYC ((`SESL_TW_NS * `SESL_CLK_MHZ) / 1000)
// Width of the write cycle counter
`define SESL_WCNT_W 24

// ****************************************
// Array and select byte layout
// ****************************************
// Byte address width
`define SESL_AW 11
// Array size in bytes
`define SESL_MEM_BYTES 2048
// Bytes in one page
`define SESL_PAGE_BYTES 16
// Array content after reset
`define SESL_RST_BYTE 8'hFF
// Select bits used as address by default
`define SESL_UPPER_BITS 3
// Type identifier field of the select byte
`define SESL_TID_HI 7
`define SESL_TID_LO 4
// Direction bit of the select byte
`define SESL_RW_BIT 0

`endif

//--- logic/sesl_pkg.sv
package sesl_pkg;

`include "sesl_cfg.svh"

    // ****************************************
    // Protocol states
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SEL,
        ST_SEL_ACK,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK,
        ST_BUSY
    } sesl_state_t;

    // Byte address
    typedef logic [`SESL_AW-1:0] sesl_addr_t;

    // Link side capture state
    typedef struct packed {
        logic bit_v;
        logic tog;
    } sesl_link_t;

    // Synchroniser chains, stage 0 first
    typedef struct packed {
        logic [2:0] scl;
        logic [2:0] sda;
        logic [2:0] tog;
        logic [1:0] wp;
        logic [2:0] cs1;
        logic [2:0] cs2;
    } sesl_sync_t;

    // Core state
    typedef struct packed {
        sesl_state_t st;
        sesl_sync_t sy;
        logic [2:0] bcnt;
        logic [7:0] sh;
        logic [7:0] sel;
        logic ack;
        logic slot10;
        logic oe;
        sesl_addr_t addr;
        logic [`SESL_PAGE_BYTES-1:0][7:0] pbuf;
        logic [`SESL_PAGE_BYTES-1:0] pval;
        logic [`SESL_WCNT_W-1:0] wcnt;
        logic [`SESL_MEM_BYTES-1:0][7:0] mem;
    } sesl_core_t;

endpackage : sesl_pkg

//--- logic/sesl_slave.sv
`timescale 1ns/1ps
`include "sesl_cfg.svh"
// Contract
// - Start is SDA falling while SCL high
// - Watch for Start except during write
// - Stop is SDA rising while SCL high
// - Read ended by no-ack and Stop idles
// - Receiver pulls SDA low on ninth pulse
// - Capture SDA on each SCL rising edge
// - Select byte MSB first, type, enables, direction
// - Respond only when enable bits match pins
// - Larger parts use select bits as address
// - Select bit zero: one reads, zero writes
// - Ack match; mismatch releases bus, goes idle
// - Write acks select, address, then data
// - Write starts only on Stop after data ack
// - After write, counter follows last written byte
// - During write, no drive and no response
// - Protected: no write, data bytes not acked
// - Reads ignore protect; sequential reads allowed
// - Ignore commands until reset release, then idle
// - Reset assertion stops all response at once
// - Stop leads to standby unless write pending
// - Unconnected enable pins count as zero; code has no pull-down, open pins must be tied low outside
// - Page write wraps lowest four address bits
// - Address advances after each byte read

// ****************************************
// Link side capture on the serial clock
// ****************************************
module sesl_link_cap (
    input wire logic i_scl,
    input wire logic i_rst_n,
    input wire logic i_sda_i,
    output logic o_bit,
    output logic o_tog
);

    // Captured bit and event toggle
    sesl_pkg::sesl_link_t lk_r;
    sesl_pkg::sesl_link_t lk_nxt;

    // Take SDA and flag the edge
    always_comb begin
        lk_nxt = lk_r;
        lk_nxt.bit_v = i_sda_i;
        lk_nxt.tog = ~lk_r.tog;
    end

    // Register on the serial clock
    always_ff @(posedge i_scl or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lk_r <= '0;
        end else begin
            lk_r <= lk_nxt;
        end
    end

    // Bit stays put until the next edge
    assign o_bit = lk_r.bit_v;
    assign o_tog = lk_r.tog;

endmodule : sesl_link_cap

// ****************************************
// Serial memory slave, core side
// ****************************************
module sesl_slave #(
    // Type identifier, arbitrary value
    parameter logic [3:0] p_type_id = 4'h5,
    // Select bits used as address, 0 to 3
    parameter int p_upper_bits = `SESL_UPPER_BITS,
    // Internal write cycle in core cycles
    parameter int p_tw_cycles = `SESL_TW_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda_i,
    output logic o_sda_o,
    output logic o_sda_oe,
    input wire logic i_chip_select_pin0,
    input wire logic i_chip_select_pin1,
    input wire logic i_chip_select_pin2,
    input wire logic i_write_protect_input,
    output logic o_write_busy,
    output logic o_standby
);

    // ****************************************
    // Helpers
    // ****************************************
    // Select byte matches type and pins
    function automatic logic f_match(
        input logic [7:0] sel,
        input logic [2:0] cs,
        input logic [3:0] tid,
        input int ub
    );
        logic ok;
        ok = (sel[`SESL_TID_HI:`SESL_TID_LO] == tid);
        for (int i = 0; i < 3; i++) begin
            // Address positions are not compared
            if (i >= ub && sel[i+1] != cs[i]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : f_match

    // Upper address bits taken from the select byte
    function automatic logic [2:0] f_upper(
        input logic [7:0] sel,
        input int ub
    );
        logic [2:0] u;
        u = 3'h0;
        for (int i = 0; i < 3; i++) begin
            if (i < ub) begin
                u[i] = sel[i+1];
            end
        end
        return u;
    endfunction : f_upper

    // Fold an address into the 256 << ub bytes the select bits can reach
    function automatic sesl_pkg::sesl_addr_t f_wrap(
        input sesl_pkg::sesl_addr_t a,
        input int ub
    );
        sesl_pkg::sesl_addr_t m;
        m = (11'h100 << ub) - 11'h1;
        return a & m;
    endfunction : f_wrap

    // ****************************************
    // State and events
    // ****************************************
    // Whole core state
    sesl_pkg::sesl_core_t c_r;
    sesl_pkg::sesl_core_t c_nxt;
    // Link side bit and toggle
    logic lk_bit;
    logic lk_tog;
    // One-cycle bus events
    logic rise_ev;
    logic fall_ev;
    logic start_ev;
    logic stop_ev;
    // Stop that starts the write cycle
    logic wr_go;
    // Byte completed by the current bit
    logic [7:0] byte_in;
    // Synchronised protect and pins
    logic wp_s;
    logic [2:0] cs_s;

    // Capture on the serial clock domain
    sesl_link_cap u_link (
        .i_scl(i_scl),
        .i_rst_n(i_rst_n),
        .i_sda_i(i_sda_i),
        .o_bit(lk_bit),
        .o_tog(lk_tog)
    );

    // Edge seen as a toggle change
    assign rise_ev = c_r.sy.tog[1] ^ c_r.sy.tog[2];
    // Clock falling from synced levels
    assign fall_ev = c_r.sy.scl[2] & ~c_r.sy.scl[1];
    // SDA falls while SCL stays high
    assign start_ev = c_r.sy.scl[1] & c_r.sy.scl[2] &
                      c_r.sy.sda[2] & ~c_r.sy.sda[1];
    // SDA rises while SCL stays high
    assign stop_ev = c_r.sy.scl[1] & c_r.sy.scl[2] &
                     ~c_r.sy.sda[2] & c_r.sy.sda[1];
    // Stop in the slot right after a data ack
    assign wr_go = stop_ev & (c_r.st == sesl_pkg::ST_WDATA) &
                   c_r.slot10 & (|c_r.pval);
    assign byte_in = {c_r.sh[6:0], lk_bit};
    assign wp_s = c_r.sy.wp[1];
    // Open pins are expected tied low outside
    assign cs_s = c_r.sy.cs2;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        c_nxt = c_r;
        // Synchronisers
        c_nxt.sy.scl = {c_r.sy.scl[1:0], i_scl};
        c_nxt.sy.sda = {c_r.sy.sda[1:0], i_sda_i};
        c_nxt.sy.tog = {c_r.sy.tog[1:0], lk_tog};
        c_nxt.sy.wp = {c_r.sy.wp[0], i_write_protect_input};
        c_nxt.sy.cs1 = {i_chip_select_pin2, i_chip_select_pin1,
                        i_chip_select_pin0};
        c_nxt.sy.cs2 = c_r.sy.cs1;

        // SDA drive changes only while SCL is low
        if (fall_ev) begin
            case (c_r.st)
                // Ack slot
                sesl_pkg::ST_SEL_ACK,
                sesl_pkg::ST_ADDR_ACK,
                sesl_pkg::ST_WDATA_ACK: begin
                    c_nxt.oe = c_r.ack;
                end
                // Read data, open drain low for zero
                sesl_pkg::ST_RDATA: begin
                    c_nxt.oe = ~c_r.sh[7];
                end
                // Released otherwise, master ack slot too
                default: begin
                    c_nxt.oe = 1'b0;
                end
            endcase
        end

        if (c_r.st == sesl_pkg::ST_BUSY) begin
            // Deaf and released during the write
            c_nxt.oe = 1'b0;
            if (c_r.wcnt == '0) begin
                // Commit the page
                for (int i = 0; i < `SESL_PAGE_BYTES; i++) begin
                    if (c_r.pval[i]) begin
                        c_nxt.mem[{c_r.addr[10:4], 4'(i)}] = c_r.pbuf[i];
                    end
                end
                // Address already follows the last byte
                c_nxt.pval = '0;
                c_nxt.st = sesl_pkg::ST_IDLE;
            end else begin
                c_nxt.wcnt = c_r.wcnt - 1'b1;
            end
        end else if (start_ev) begin
            // Start or repeated start
            c_nxt.st = sesl_pkg::ST_SEL;
            c_nxt.bcnt = 3'h0;
            c_nxt.oe = 1'b0;
            c_nxt.slot10 = 1'b0;
            c_nxt.pval = '0;
        end else if (stop_ev) begin
            c_nxt.oe = 1'b0;
            c_nxt.slot10 = 1'b0;
            if (wr_go) begin
                // Launch the internal write
                c_nxt.st = sesl_pkg::ST_BUSY;
                c_nxt.wcnt = `SESL_WCNT_W'(p_tw_cycles - 1);
            end else begin
                // Back to standby, nothing written
                c_nxt.st = sesl_pkg::ST_IDLE;
                c_nxt.pval = '0;
            end
        end else if (rise_ev) begin
            case (c_r.st)
                // Select byte
                sesl_pkg::ST_SEL: begin
                    c_nxt.sh = byte_in;
                    c_nxt.bcnt = c_r.bcnt + 3'h1;
                    if (c_r.bcnt == 3'h7) begin
                        c_nxt.sel = byte_in;
                        c_nxt.ack = f_match(byte_in, cs_s, p_type_id,
                                            p_upper_bits);
                        c_nxt.st = sesl_pkg::ST_SEL_ACK;
                    end
                end
                // End of select ack slot
                sesl_pkg::ST_SEL_ACK: begin
                    c_nxt.bcnt = 3'h0;
                    if (!c_r.ack) begin
                        // Drop out, rest of transfer ignored
                        c_nxt.st = sesl_pkg::ST_IDLE;
                    end else if (c_r.sel[`SESL_RW_BIT]) begin
                        // Read, protect input not consulted
                        c_nxt.st = sesl_pkg::ST_RDATA;
                        c_nxt.sh = c_r.mem[c_r.addr];
                    end else begin
                        c_nxt.st = sesl_pkg::ST_ADDR;
                    end
                end
                // Address byte
                sesl_pkg::ST_ADDR: begin
                    c_nxt.sh = byte_in;
                    c_nxt.bcnt = c_r.bcnt + 3'h1;
                    if (c_r.bcnt == 3'h7) begin
                        c_nxt.addr = {f_upper(c_r.sel, p_upper_bits),
                                      byte_in};
                        c_nxt.ack = 1'b1;
                        c_nxt.st = sesl_pkg::ST_ADDR_ACK;
                    end
                end
                // End of address ack slot
                sesl_pkg::ST_ADDR_ACK: begin
                    c_nxt.bcnt = 3'h0;
                    c_nxt.slot10 = 1'b0;
                    c_nxt.pval = '0;
                    c_nxt.st = sesl_pkg::ST_WDATA;
                end
                // Data byte
                sesl_pkg::ST_WDATA: begin
                    c_nxt.sh = byte_in;
                    c_nxt.bcnt = c_r.bcnt + 3'h1;
                    // Slot ten lasts until its second clock rise, since
                    // the Stop's own clock rise falls inside that slot
                    c_nxt.slot10 = c_r.slot10 & (c_r.bcnt == 3'h0);
                    if (c_r.bcnt == 3'h7) begin
                        c_nxt.ack = ~wp_s;
                        c_nxt.st = sesl_pkg::ST_WDATA_ACK;
                        if (!wp_s) begin
                            c_nxt.pbuf[c_r.addr[3:0]] = byte_in;
                            c_nxt.pval[c_r.addr[3:0]] = 1'b1;
                            // Roll over inside the page
                            c_nxt.addr[3:0] = c_r.addr[3:0] + 4'h1;
                        end
                    end
                end
                // End of data ack slot
                sesl_pkg::ST_WDATA_ACK: begin
                    c_nxt.bcnt = 3'h0;
                    c_nxt.slot10 = 1'b1;
                    c_nxt.st = sesl_pkg::ST_WDATA;
                end
                // Read byte goes out
                sesl_pkg::ST_RDATA: begin
                    c_nxt.sh = {c_r.sh[6:0], 1'b0};
                    c_nxt.bcnt = c_r.bcnt + 3'h1;
                    if (c_r.bcnt == 3'h7) begin
                        c_nxt.addr = f_wrap(c_r.addr + 11'h1,
                                            p_upper_bits);
                        c_nxt.st = sesl_pkg::ST_RACK;
                    end
                end
                // Master ack slot
                sesl_pkg::ST_RACK: begin
                    c_nxt.bcnt = 3'h0;
                    if (!lk_bit) begin
                        // Sequential read continues
                        c_nxt.st = sesl_pkg::ST_RDATA;
                        c_nxt.sh = c_r.mem[c_r.addr];
                    end else begin
                        c_nxt.st = sesl_pkg::ST_IDLE;
                    end
                end
                // Standby ignores bits
                default: begin
                    c_nxt.bcnt = c_r.bcnt;
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    // Reset stands for power-on reset
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            c_r <= '0;
            c_r.mem <= {`SESL_MEM_BYTES{`SESL_RST_BYTE}};
        end else begin
            c_r <= c_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Open drain: only ever pulls low
    assign o_sda_o = 1'b0;
    assign o_sda_oe = c_r.oe;
    assign o_write_busy = (c_r.st == sesl_pkg::ST_BUSY);
    assign o_standby = (c_r.st == sesl_pkg::ST_IDLE);

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_start_enter_sel: assert property (
        start_ev && c_r.st != sesl_pkg::ST_BUSY |=> c_r.st == sesl_pkg::ST_SEL)
        else $error("start not taken");

    a_busy_ignores_bus: assert property (
        c_r.st == sesl_pkg::ST_BUSY && c_r.wcnt != '0
        |=> c_r.st == sesl_pkg::ST_BUSY)
        else $error("busy left early");

    a_busy_no_drive: assert property (
        c_r.st == sesl_pkg::ST_BUSY |=> !o_sda_oe)
        else $error("drive during write");

    a_stop_to_idle: assert property (
        stop_ev && !wr_go && c_r.st != sesl_pkg::ST_BUSY
        |=> o_standby && !o_sda_oe)
        else $error("stop did not idle");

    a_write_launch: assert property (
        wr_go |=> o_write_busy &&
        c_r.wcnt == `SESL_WCNT_W'(p_tw_cycles - 1))
        else $error("write not launched");

    a_write_end: assert property (
        o_write_busy && c_r.wcnt == '0
        |=> o_standby && c_r.pval == '0 && $stable(c_r.addr))
        else $error("write end wrong");

    a_sel_mismatch: assert property (
        rise_ev && c_r.st == sesl_pkg::ST_SEL_ACK && !c_r.ack
        |=> o_standby ##1 !o_sda_oe)
        else $error("mismatch not dropped");

    a_sel_type_check: assert property (
        rise_ev && c_r.st == sesl_pkg::ST_SEL && c_r.bcnt == 3'h7 &&
        byte_in[7:4] != p_type_id |=> !c_r.ack)
        else $error("wrong type acked");

    a_addr_ack_drive: assert property (
        fall_ev && c_r.st == sesl_pkg::ST_ADDR_ACK |=> o_sda_oe)
        else $error("address not acked");

    a_wp_no_ack: assert property (
        rise_ev && c_r.st == sesl_pkg::ST_WDATA && c_r.bcnt == 3'h7 && wp_s
        |=> !c_r.ack && $stable(c_r.pval))
        else $error("protected byte taken");

    a_page_wrap: assert property (
        rise_ev && c_r.st == sesl_pkg::ST_WDATA && c_r.bcnt == 3'h7 && !wp_s
        |=> c_r.addr[10:4] == $past(c_r.addr[10:4]) &&
        c_r.addr[3:0] == $past(c_r.addr[3:0]) + 4'h1)
        else $error("page address wrong");

    a_read_advance: assert property (
        rise_ev && c_r.st == sesl_pkg::ST_RDATA && c_r.bcnt == 3'h7
        |=> c_r.addr == f_wrap($past(c_r.addr) + 11'h1, p_upper_bits))
        else $error("read address not advanced");

    a_bit_capture: assert property (
        rise_ev && c_r.st == sesl_pkg::ST_SEL |=> c_r.sh[0] == $past(lk_bit))
        else $error("bit not captured");

    a_read_nack_idle: assert property (
        rise_ev && c_r.st == sesl_pkg::ST_RACK && lk_bit |=> o_standby)
        else $error("nack did not idle");

    c_byte_write: cover property (wr_go ##1 o_write_busy);
    c_seq_read: cover property (
        rise_ev && c_r.st == sesl_pkg::ST_RACK && !lk_bit);
    c_mismatch: cover property (
        rise_ev && c_r.st == sesl_pkg::ST_SEL_ACK && !c_r.ack);
    c_wp_nack: cover property (
        rise_ev && c_r.st == sesl_pkg::ST_WDATA && c_r.bcnt == 3'h7 && wp_s);

endmodule : sesl_slave

//--- verification/sesl_bus_master.sv
`timescale 1ns/1ps
// ****************************************
// Bus master model
// ****************************************
module sesl_bus_master (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_pull
);
    logic lclk = 1'b0; // Link timing base, 12 ns period
    // Clock stands high between frames; timing base is free of core phase
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
        #1.7;
        forever #6 lclk = ~lclk;
    end
    // One half period of the serial clock, 96 ns
    task automatic ph();
        repeat (8) @(posedge lclk);
    endtask : ph
    // Start or repeated Start: data falls while clock high
    task automatic start();
        // Let the clock fall settle before touching data
        @(posedge lclk);
        o_sda_pull = 1'b0;
        ph();
        o_scl = 1'b1;
        ph();
        o_sda_pull = 1'b1;
        ph();
        o_scl = 1'b0;
    endtask : start
    // Stop: data rises while clock high
    task automatic stop();
        // Let the clock fall settle before touching data
        @(posedge lclk);
        o_sda_pull = 1'b1;
        ph();
        o_scl = 1'b1;
        ph();
        o_sda_pull = 1'b0;
        ph();
    endtask : stop
    // Eight bits MSB first, then the ninth slot; data moves only while clock low
    task automatic xfer(input logic [7:0] d, input logic b9, output logic [7:0] q,
        output logic s9);
        for (int i = 8; i >= 0; i--) begin
            // Data moves one link tick after the clock fell
            @(posedge lclk);
            o_sda_pull = (i == 0) ? ~b9 : ~d[i - 1];
            ph();
            o_scl = 1'b1;
            if (i == 0) begin
                s9 = i_sda;
            end else begin
                q[i - 1] = i_sda;
            end
            ph();
            o_scl = 1'b0;
        end
    endtask : xfer
endmodule : sesl_bus_master

//--- verification/tb_top.sv
`timescale 1ns/1ps
// ****************************************
// Testbench top
// ****************************************
module tb_top;
    localparam int P_TW = 2000; // Shortened write cycle
    localparam int P_UB = 1; // One select bit carries address
    localparam logic [3:0] P_TID = 4'h5; // Arbitrary type identifier
    localparam int AMASK = (256 << P_UB) - 1;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl;
    logic pull;
    logic sda;
    logic sda_o;
    logic oe;
    logic [1:0] cs_hi = 2'h2; // Levels on enable pins 2 and 1
    logic wp = 1'b0;
    logic busy;
    logic stby;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int blen = 0;
    int blast = 0;
    int mem[512]; // Reference array
    int cur = 0; // Reference address counter
    always #2 clk = ~clk;
    assign sda = (pull || (oe && !sda_o)) ? 1'b0 : 1'b1; // Open drain wire, pull-up
    sesl_bus_master m (.i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
    sesl_slave #(.p_type_id(P_TID), .p_upper_bits(P_UB), .p_tw_cycles(P_TW)) dut (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda_i(sda),
        .o_sda_o(sda_o), .o_sda_oe(oe), .i_chip_select_pin0(1'b0),
        .i_chip_select_pin1(cs_hi[0]), .i_chip_select_pin2(cs_hi[1]),
        .i_write_protect_input(wp), .o_write_busy(busy), .o_standby(stby));
    // Busy length meter and run ceiling
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (busy === 1'b1) begin
            blen <= blen + 1;
        end else if (blen != 0) begin
            blast <= blen;
            blen <= 0;
        end
        if (cyc == 95000) begin
            num_errors++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("compared %0d, mismatched %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    // Wait core cycles, then step just past the edge
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles
    task automatic wait_busy(input logic lvl, input int lim);
        int k;
        k = 0;
        while (busy !== lvl && k < lim) begin
            @(posedge clk);
            k++;
        end
        #1;
    endtask : wait_busy
    // Start plus one byte, returns the device acknowledge
    task automatic sel(input logic [7:0] b, output logic ack);
        m.start();
        wb(b, ack);
    endtask : sel
    task automatic wb(input logic [7:0] d, output logic ack);
        logic [7:0] q;
        logic s;
        m.xfer(d, 1'b1, q, s);
        ack = ~s;
    endtask : wb
    // Page write of n bytes, then busy poll and length check
    task automatic pwrite(input int a, input int n);
        logic ack;
        logic [7:0] d;
        logic wr;
        wr = (n > 0) && !wp;
        sel({P_TID, cs_hi, a[8], 1'b0}, ack);
        chk(32'(ack), 32'h1);
        wb(a[7:0], ack);
        chk(32'(ack), 32'h1);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            wb(d, ack);
            chk(32'(ack), 32'(!wp));
            if (!wp) begin
                mem[(a & ~15) | ((a + k) & 15)] = d;
            end
        end
        m.stop();
        if (wr) begin
            cur = (a & ~15) | ((a + n) & 15);
        end
        wait_busy(1'b1, 20);
        chk(32'(busy), 32'(wr));
        sel({P_TID, cs_hi, 2'b00}, ack);
        m.stop();
        chk(32'(ack), 32'(!wr));
        wait_busy(1'b0, P_TW + 50);
        cycles(4);
        chk(32'(stby), 32'h1);
        if (wr) begin
            chk(blast, P_TW);
        end
    endtask : pwrite
    // Read n bytes, after a dummy write when rnd is set
    task automatic rread(input int a, input int n, input logic rnd);
        logic ack;
        logic [7:0] q;
        logic s;
        if (rnd) begin
            sel({P_TID, cs_hi, a[8], 1'b0}, ack);
            wb(a[7:0], ack);
            cur = a;
        end
        sel({P_TID, cs_hi, 1'(cur >> 8), 1'b1}, ack);
        chk(32'(ack), 32'h1);
        for (int k = 0; k < n; k++) begin
            m.xfer(8'hFF, k == n - 1, q, s);
            chk(32'(q), 32'(mem[cur]));
            cur = (cur + 1) & AMASK;
        end
        m.stop();
        cycles(4);
        chk(32'(stby), 32'h1);
    endtask : rread
    task automatic do_reset();
        rst_n = 1'b0;
        cycles(10);
        chk(32'({oe, busy, stby}), 32'h1);
        rst_n = 1'b1;
        cycles(4);
        chk(32'({sda_o, oe, busy, stby}), 32'h1);
        cur = 0;
        foreach (mem[i]) mem[i] = 255;
    endtask : do_reset
    // Main sequence
    initial begin
        logic ack;
        int a;
        void'($urandom(32'h5200d710));
        do_reset();
        // Four enable patterns and a wrong type identifier
        for (int j = 0; j < 5; j++) begin
            sel({(j < 4) ? P_TID : ~P_TID, 2'(j), 2'b00}, ack);
            m.stop();
            cycles(4);
            chk(32'(ack), 32'(j == cs_hi));
            chk(32'(stby), 32'h1);
        end
        a = ($urandom & AMASK) | 13;
        pwrite(a, 6);
        rread(0, 1, 1'b0);
        rread(a & ~15, 16, 1'b1);
        wp = 1'b1;
        pwrite(a, 2);
        rread(a, 2, 1'b1);
        wp = 1'b0;
        pwrite(a, 0);
        for (int r = 0; r < 2; r++) begin
            a = $urandom & AMASK;
            pwrite(a, 1 + ($urandom % 8));
            rread(a, 8, 1'b1);
        end
        // Reset while the device drives read data
        sel({P_TID, cs_hi, 1'(cur >> 8), 1'b1}, ack);
        cycles(30);
        rst_n = 1'b0;
        #1;
        chk(32'(oe), 32'h0);
        m.stop();
        do_reset();
        rread(5, 1, 1'b1);
        conclude();
    end
endmodule : tb_top
